//--- core/serial_port_pkg.sv
// Constants and types shared by the serial command port
//
// Overview of operation
// - Baud selectable 9600, 19200, 57600, 115200.
// - Frame is start, eight data, stop.
// - RTS/CTS hardware handshake both directions.
// - Host present only while DTR asserted.
// - Characters received without DTR are discarded.
// - DSR asserted while port enabled.
// - CTS drops when receive side cannot accept.
// - Transmit starts only while host asserts RTS.
// - ASCII lines end with CR and/or LF.
// - Lines delivered to command processing unchanged.
`default_nettype none
package serial_port_pkg;
   // ****************************************************
   // Clock and bit timing
   // ****************************************************
   localparam int unsigned CLK_HZ       = 100_000_000;    // System clock rate
   localparam int unsigned BAUD_9600    = 9600;           // Selectable rates
   localparam int unsigned BAUD_19200   = 19200;
   localparam int unsigned BAUD_57600   = 57600;
   localparam int unsigned BAUD_115200  = 115200;
   localparam int unsigned DIV_W        = 14;             // Width of bit divider
   localparam logic [DIV_W-1:0] DIV_9600   = DIV_W'(CLK_HZ / BAUD_9600);
   localparam logic [DIV_W-1:0] DIV_19200  = DIV_W'(CLK_HZ / BAUD_19200);
   localparam logic [DIV_W-1:0] DIV_57600  = DIV_W'(CLK_HZ / BAUD_57600);
   localparam logic [DIV_W-1:0] DIV_115200 = DIV_W'(CLK_HZ / BAUD_115200);
   localparam logic [DIV_W-1:0] DIV_ONE    = 14'h0001;
   localparam logic [DIV_W-1:0] DIV_ZERO   = 14'h0000;
   // ****************************************************
   // Baud select codes
   // ****************************************************
   localparam logic [1:0] SEL_9600   = 2'h0;
   localparam logic [1:0] SEL_19200  = 2'h1;
   localparam logic [1:0] SEL_57600  = 2'h2;
   localparam logic [1:0] SEL_115200 = 2'h3;
   // ****************************************************
   // Framing
   // ****************************************************
   localparam int unsigned DATA_BITS = 8;                 // Data bits per frame
   localparam logic [2:0]  LAST_BIT  = 3'h7;              // Index of last data bit
   localparam logic [2:0]  FIRST_BIT = 3'h0;
   localparam logic [7:0]  ASCII_CR  = 8'h0d;             // Line terminators
   localparam logic [7:0]  ASCII_LF  = 8'h0a;
   // ****************************************************
   // Receive buffer
   // ****************************************************
   localparam int unsigned RX_AW       = 6;               // 64 entry buffer
   localparam logic [RX_AW:0] RX_DEPTH = 7'h40;
   localparam logic [RX_AW:0] CTS_OFF  = 7'h30;           // Drop CTS at this fill
   localparam logic [RX_AW:0] CNT_ONE  = 7'h01;
   localparam logic [RX_AW-1:0] PTR_ONE = 6'h01;
   // Line state machine for both directions
   typedef enum logic [1:0] {LN_IDLE, LN_START, LN_DATA, LN_STOP} line_st_t;
endpackage : serial_port_pkg
`default_nettype wire

//--- core/rx_char_mem.sv
// Receive character memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module rx_char_mem
   import serial_port_pkg::*;
(
   // Clock
   input  wire logic             clk_sys,
   input  wire logic             ce,
   // Write side
   input  wire logic             wr_en,
   input  wire logic [RX_AW-1:0] wr_addr,
   input  wire logic [7:0]       wr_data,
   // Read side
   input  wire logic             rd_en,
   input  wire logic [RX_AW-1:0] rd_addr,
   output logic      [7:0]       rd_data
);
   // ****************************************************
   // Storage
   // ****************************************************
   logic [7:0] mem_q [2**RX_AW];     // Character array, no reset needed

   // Write and registered read
   always_ff @(posedge clk_sys) begin
      if (ce && wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
      if (ce && rd_en) begin
         rd_data <= mem_q[rd_addr];
      end
   end
endmodule // rx_char_mem
`default_nettype wire

//--- core/serial_command_port.sv
// Serial command port: framing, handshake and receive buffer
`timescale 1ns/1ps
`default_nettype none
module serial_command_port
   import serial_port_pkg::*;
(
   // Clock, reset, enable
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       ce,
   // Configuration
   input  wire logic       port_enable,
   input  wire logic [1:0] baud_sel,
   // Serial pins, true levels (1 = asserted / mark)
   input  wire logic       rxd,
   input  wire logic       dtr,
   input  wire logic       rts,
   output logic            txd,
   output logic            cts,
   output logic            dsr,
   // Transmit characters from response logic
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   // Received characters to command parser
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_eol,
   input  wire logic       rx_ready,
   // Status
   output logic            rx_overrun,
   output logic            host_present
);
   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   logic [2:0] meta_q;               // First stage, read only by second
   logic [2:0] sync_q;               // Second stage: rxd, dtr, rts

   // Two flops on every pin input; idle levels at reset
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         meta_q <= 3'h1;
         sync_q <= 3'h1;
      end else if (ce) begin
         meta_q <= {rts, dtr, rxd};
         sync_q <= meta_q;
      end
   end

   // Synchronised pin levels; only these are read by the logic below.
   // DTR low removes presence at once, so a host that drops DTR in the
   // middle of a character loses that character rather than half of it.
   wire rxd_s = sync_q[0];
   wire dtr_s = sync_q[1];
   wire rts_s = sync_q[2];
   wire present = port_enable && dtr_s;

   // ****************************************************
   // Bit period selection
   // ****************************************************
   logic [DIV_W-1:0] div_sel;        // Cycles per bit
   assign div_sel = (baud_sel == SEL_9600)  ? DIV_9600  :
                    (baud_sel == SEL_19200) ? DIV_19200 :
                    (baud_sel == SEL_57600) ? DIV_57600 : DIV_115200;
   // Half a bit period moves the receive sampling point to bit centre;
   // the odd cycle lost on odd divisors is far inside the bit tolerance
   wire [DIV_W-1:0] div_half = {1'b0, div_sel[DIV_W-1:1]};

   // ****************************************************
   // Transmitter
   // ****************************************************
   line_st_t         tx_st_q;        // Transmit line state
   logic [DIV_W-1:0] tx_cnt_q;       // Cycles left in bit
   logic [2:0]       tx_bit_q;       // Data bit index
   logic [7:0]       tx_sh_q;        // Shift register
   logic             txd_q;          // Line level

   // Accept a character only when idle and host has RTS up
   assign tx_ready = (tx_st_q == LN_IDLE) && rts_s && port_enable;
   wire tx_take    = tx_valid && tx_ready;
   wire tx_tick    = (tx_cnt_q == DIV_ONE);

   // Frame out; RTS is checked only between characters so a frame is never cut
   // A started frame always completes: cutting it would leave the host
   // with a broken character instead of a delayed one
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tx_st_q  <= LN_IDLE;
         tx_cnt_q <= DIV_ZERO;
         tx_bit_q <= FIRST_BIT;
         tx_sh_q  <= 8'h00;
         txd_q    <= 1'b1;
      end else if (ce) begin
         unique case (tx_st_q)
            LN_IDLE: begin
               txd_q <= 1'b1;
               if (tx_take) begin
                  tx_sh_q  <= tx_data;
                  txd_q    <= 1'b0;                       // Start bit
                  tx_cnt_q <= div_sel;
                  tx_st_q  <= LN_START;
               end
            end
            LN_START: begin
               if (tx_tick) begin
                  txd_q    <= tx_sh_q[0];
                  tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                  tx_bit_q <= FIRST_BIT;
                  tx_cnt_q <= div_sel;
                  tx_st_q  <= LN_DATA;
               end else begin
                  tx_cnt_q <= tx_cnt_q - DIV_ONE;
               end
            end
            LN_DATA: begin
               if (tx_tick) begin
                  tx_cnt_q <= div_sel;
                  if (tx_bit_q == LAST_BIT) begin
                     txd_q   <= 1'b1;                     // Stop bit, no parity
                     tx_st_q <= LN_STOP;
                  end else begin
                     txd_q    <= tx_sh_q[0];
                     tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                     tx_bit_q <= tx_bit_q + 3'h1;
                  end
               end else begin
                  tx_cnt_q <= tx_cnt_q - DIV_ONE;
               end
            end
            LN_STOP: begin
               if (tx_tick) begin
                  tx_st_q <= LN_IDLE;
               end else begin
                  tx_cnt_q <= tx_cnt_q - DIV_ONE;
               end
            end
         endcase
      end
   end
   assign txd = txd_q;

   // ****************************************************
   // Receiver
   // ****************************************************
   line_st_t         rx_st_q;        // Receive line state
   logic [DIV_W-1:0] rx_cnt_q;       // Cycles to next sample
   logic [2:0]       rx_bit_q;       // Data bit index
   logic [7:0]       rx_sh_q;        // Assembled character
   logic             rx_done_q;      // One-cycle character strobe
   logic             rx_drop_q;      // Character seen without host

   // The counters reload from div_sel at every tick but the stop bit's, so a change of
   // baud_sel only takes effect cleanly between characters; software
   // must switch rates while both directions are idle
   wire rx_tick = (rx_cnt_q == DIV_ONE);

   // Sample mid-bit; a false start (line high at mid start) returns to idle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rx_st_q   <= LN_IDLE;
         rx_cnt_q  <= DIV_ZERO;
         rx_bit_q  <= FIRST_BIT;
         rx_sh_q   <= 8'h00;
         rx_done_q <= 1'b0;
         rx_drop_q <= 1'b0;
      end else if (ce) begin
         rx_done_q <= 1'b0;
         unique case (rx_st_q)
            LN_IDLE: begin
               if (!rxd_s && port_enable) begin
                  rx_cnt_q  <= div_half;
                  rx_drop_q <= !dtr_s;
                  rx_st_q   <= LN_START;
               end
            end
            LN_START: begin
               if (rx_tick) begin
                  rx_cnt_q <= div_sel;
                  rx_bit_q <= FIRST_BIT;
                  rx_st_q  <= rxd_s ? LN_IDLE : LN_DATA;
               end else begin
                  rx_cnt_q <= rx_cnt_q - DIV_ONE;
               end
            end
            LN_DATA: begin
               if (rx_tick) begin
                  rx_sh_q  <= {rxd_s, rx_sh_q[7:1]};      // LSB first
                  rx_cnt_q <= div_sel;
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == LAST_BIT) begin
                     rx_st_q <= LN_STOP;
                  end
               end else begin
                  rx_cnt_q <= rx_cnt_q - DIV_ONE;
               end
               if (!dtr_s) begin
                  rx_drop_q <= 1'b1;
               end
            end
            LN_STOP: begin
               if (rx_tick) begin
                  // Framing error (stop low) drops the character
                  rx_done_q <= rxd_s && !rx_drop_q && present;
                  rx_st_q   <= LN_IDLE;
               end else begin
                  rx_cnt_q <= rx_cnt_q - DIV_ONE;
               end
            end
         endcase
      end
   end

   // ****************************************************
   // Receive buffer pointers and fill level
   // ****************************************************
   logic [RX_AW-1:0] wr_ptr_q;       // Next write slot
   logic [RX_AW-1:0] rd_ptr_q;       // Next read slot
   logic [RX_AW:0]   fill_q;         // Characters held, incl. output register
   logic             out_vld_q;      // Output register holds a character
   logic             ovr_q;          // Sticky overrun flag

   // The output register counts as one slot of the fill level, so the
   // memory itself never holds more than the depth minus one while the
   // parser has a character pending
   wire buf_full  = (fill_q == RX_DEPTH);
   wire push      = rx_done_q && !buf_full;
   wire mem_empty = (wr_ptr_q == rd_ptr_q) && (fill_q == (out_vld_q ? CNT_ONE : 7'h00))
                    && !(fill_q == RX_DEPTH);
   wire pop_out   = out_vld_q && rx_ready;
   wire load_out  = !mem_empty && (!out_vld_q || rx_ready);

   // Pointer and count bookkeeping; loss only if the host ignores CTS
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_ptr_q  <= 6'h00;
         rd_ptr_q  <= 6'h00;
         fill_q    <= 7'h00;
         out_vld_q <= 1'b0;
         ovr_q     <= 1'b0;
      end else if (ce) begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + PTR_ONE;
         end
         if (load_out) begin
            rd_ptr_q <= rd_ptr_q + PTR_ONE;
         end
         if (push && !pop_out) begin
            fill_q <= fill_q + CNT_ONE;
         end else if (pop_out && !push) begin
            fill_q <= fill_q - CNT_ONE;
         end
         if (load_out) begin
            out_vld_q <= 1'b1;
         end else if (pop_out) begin
            out_vld_q <= 1'b0;
         end
         if (rx_done_q && buf_full) begin
            ovr_q <= 1'b1;
         end else if (!present) begin
            ovr_q <= 1'b0;
         end
      end
   end

   // Memory reads are registered, so a character written in one cycle
   // can be read no earlier than the next one
   // Character memory, read into the output register
   rx_char_mem u_mem (
      .clk_sys (clk_sys),
      .ce      (ce),
      .wr_en   (push),
      .wr_addr (wr_ptr_q),
      .wr_data (rx_sh_q),
      .rd_en   (load_out),
      .rd_addr (rd_ptr_q),
      .rd_data (rx_data)
   );

   // Characters pass unaltered; terminators are flagged for the parser
   assign rx_valid = out_vld_q;
   assign rx_eol   = out_vld_q && ((rx_data == ASCII_CR) || (rx_data == ASCII_LF));

   // ****************************************************
   // Handshake outputs
   // ****************************************************
   logic cts_q;                      // Registered clear-to-send

   // Margin of sixteen slots covers characters the host has in flight
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cts_q <= 1'b0;
      end else if (ce) begin
         cts_q <= present && (fill_q < CTS_OFF);
      end
   end
   // CTS comes from a flop so it never glitches on the pin; DSR is a
   // plain copy of the enable that the host may watch or ignore
   assign cts          = cts_q;
   assign dsr          = port_enable;
   assign rx_overrun   = ovr_q;
   assign host_present = present;
endmodule // serial_command_port
`default_nettype wire

//--- testbench/serial_command_port_props.sv
// Port checker of the serial command port and its bind
`timescale 1ns/1ps
`default_nettype none
module serial_command_port_props
   import serial_port_pkg::*;
(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       srst,
   // Configuration and control lines
   input wire logic       port_enable,
   input wire logic       rts,
   input wire logic       txd,
   input wire logic       cts,
   input wire logic       dsr,
   // Character streams
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       rx_eol,
   input wire logic       rx_ready,
   // Status
   input wire logic       rx_overrun,
   input wire logic       host_present
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // A character taken, then the start bit held low
   sequence s_take; tx_valid && tx_ready; endsequence
   sequence s_start; !txd [*3]; endsequence
   a_dsr_enable: assert property (dsr == port_enable)
      else $error("dsr differs from port enable");
   a_ready_rts: assert property (!rts [*3] |-> !tx_ready)
      else $error("transmit offered without rts");
   a_ready_enable: assert property (tx_ready |-> port_enable)
      else $error("transmit offered while disabled");
   a_idle_mark: assert property (tx_ready |-> txd)
      else $error("line not at mark while idle");
   a_start_bit: assert property (s_take |=> s_start)
      else $error("start bit missing after take");
   a_hold_char: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("received character not held");
   a_eol_flag: assert property (rx_eol == (rx_valid && (rx_data == ASCII_CR || rx_data == ASCII_LF)))
      else $error("line end flag wrong");
   a_cts_host: assert property (!host_present [*2] |=> !cts)
      else $error("cts high without host");
   a_overrun_clear: assert property (!host_present [*2] |=> !rx_overrun)
      else $error("overrun kept without host");
endmodule // serial_command_port_props
bind serial_command_port serial_command_port_props i_props (
   .clk_sys(clk_sys), .srst(srst), .port_enable(port_enable), .rts(rts), .txd(txd), .cts(cts),
   .dsr(dsr), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
   .rx_eol(rx_eol), .rx_ready(rx_ready), .rx_overrun(rx_overrun), .host_present(host_present)
);
`default_nettype wire

//--- testbench/host_serial_model.sv
// Behavioural host serial port: sends under CTS and decodes the device line
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
   // Clock and bit period
   input  wire logic        clk_sys,
   input  wire logic [15:0] bit_cycles,
   // Serial lines
   output logic             rxd,
   input  wire logic        txd,
   input  wire logic        cts,
   // Decoded device characters
   output logic             got_valid,
   output logic [7:0]       got_byte
);
   initial begin
      rxd = 1'b1;
   end
   // One character per burst; ignore_cts only for the character sent while the host is absent
   task automatic send(input logic [7:0] b, input logic ignore_cts, output logic late);
      int n;
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (n = 0; n < 4000 && !ignore_cts && cts !== 1'b1; n++) @(posedge clk_sys);
      late = (n == 4000);
      for (n = 0; n < 10; n++) begin
         @(posedge clk_sys);
         #1 rxd = f[n];
         repeat (bit_cycles - 1) @(posedge clk_sys);
      end
   endtask
   // Mid-bit sampling of the device line; a low stop bit gives no result
   initial begin : rx_dec
      logic [7:0] v;
      int i;
      got_valid = 1'b0;
      got_byte = 8'h00;
      forever begin
         @(negedge txd);
         repeat (bit_cycles / 2) @(posedge clk_sys);
         for (i = 0; i < 8; i++) begin
            repeat (bit_cycles) @(posedge clk_sys);
            v[i] = txd;
         end
         repeat (bit_cycles) @(posedge clk_sys);
         got_byte <= v;
         got_valid <= txd;
         @(posedge clk_sys);
         got_valid <= 1'b0;
      end
   end
endmodule // host_serial_model
`default_nettype wire

//--- testbench/serial_command_port_bench.sv
// Self-checking bench of the serial command port
`timescale 1ns/1ps
`default_nettype none
module serial_command_port_bench;
   import serial_port_pkg::*;
   logic        clk_sys, srst, port_enable, dtr, rts, tx_valid, rx_ready, late;
   logic [1:0]  baud_sel;
   logic [7:0]  tx_data, rx_data, got_byte;
   logic        rxd, txd, cts, dsr, tx_ready, rx_valid, rx_eol, rx_overrun, host_present, got_valid;
   logic [15:0] bit_cycles;
   logic [7:0]  exp_rx[$], exp_tx[$];
   int          num_errors = 0, samples_checked = 0, seed = 32'hb2c1, k;
   serial_command_port i_serial_command_port (.clk_sys(clk_sys), .srst(srst), .ce(1'b1),
      .port_enable(port_enable), .baud_sel(baud_sel), .rxd(rxd), .dtr(dtr), .rts(rts), .txd(txd),
      .cts(cts), .dsr(dsr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_eol(rx_eol), .rx_ready(rx_ready),
      .rx_overrun(rx_overrun), .host_present(host_present));
   host_serial_model i_host_serial_model (.clk_sys(clk_sys), .bit_cycles(bit_cycles), .rxd(rxd),
      .txd(txd), .cts(cts), .got_valid(got_valid), .got_byte(got_byte));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic summarize();
      $display("errors %0d, comparisons %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic give_up();
      num_errors++;
      summarize();
   endtask
   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
      end
   endtask
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: char %h, wanted %h", $time, got, exp);
      end
   endtask
   // Hold the request until the edge that sees tx_ready high
   task automatic send_tx(input logic [7:0] c);
      int n;
      @(posedge clk_sys);
      #1 tx_data = c;
      tx_valid = 1'b1;
      exp_tx.push_back(c);
      for (n = 0; n < 20000 && tx_ready !== 1'b1; n++) @(posedge clk_sys) #1;
      if (n == 20000) give_up();
      @(posedge clk_sys);
      #1 tx_valid = 1'b0;
   endtask
   // Host character with its expected delivery noted first
   task automatic host_char(input logic [7:0] c, input logic keep);
      if (keep) exp_rx.push_back(c);
      i_host_serial_model.send(c, !keep, late);
      if (late) give_up();
   endtask
   task automatic wait_empty();
      int n;
      for (n = 0; n < 20000 && exp_rx.size() + exp_tx.size() > 0; n++) @(posedge clk_sys);
      if (n == 20000) give_up();
   endtask
   // Random stalls of the command parser
   always @(posedge clk_sys) begin
      #1 rx_ready = 1'($random(seed));
   end
   // Results taken off the queues as they appear
   always @(posedge clk_sys) begin : watch
      logic [7:0] e;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
         e = exp_rx.size() ? exp_rx.pop_front() : 8'hff;
         check_byte(rx_data, e);
         check_bit(rx_eol, e == ASCII_CR || e == ASCII_LF);
      end
      if (got_valid === 1'b1) begin
         e = exp_tx.size() ? exp_tx.pop_front() : 8'hff;
         check_byte(got_byte, e);
      end
   end
   initial begin : watchdog
      repeat (90000) @(posedge clk_sys);
      give_up();
   end
   initial begin : main
      srst = 1'b1;
      port_enable = 1'b1;
      baud_sel = SEL_115200;
      bit_cycles = 16'd868;
      dtr = 1'b1;
      rts = 1'b1;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      repeat (3) @(posedge clk_sys);
      #1 srst = 1'b0;
      check_bit(cts, 1'b0);
      check_bit(txd, 1'b1);
      repeat (5) @(posedge clk_sys);
      check_bit(cts, 1'b1);
      check_bit(dsr, 1'b1);
      #1 rts = 1'b0;
      repeat (4) @(posedge clk_sys);
      check_bit(tx_ready, 1'b0);
      #1 rts = 1'b1;
      // Full duplex at the fast rate: host sends two random characters and CR, device one random character and LF
      fork
         for (k = 0; k < 3; k++) host_char(k == 2 ? ASCII_CR : 8'($random(seed)) & 8'h7f, 1'b1);
         begin
            send_tx(8'($random(seed)) & 8'h7f);
            send_tx(ASCII_LF);
         end
      join
      wait_empty();
      #1 baud_sel = SEL_57600;
      bit_cycles = 16'd1736;
      fork
         host_char(8'h41, 1'b1);
         send_tx(8'h5a);
      join
      wait_empty();
      // A character without the host present is discarded
      #1 dtr = 1'b0;
      repeat (4) @(posedge clk_sys);
      check_bit(host_present, 1'b0);
      check_bit(cts, 1'b0);
      host_char(8'h33, 1'b0);
      #1 dtr = 1'b1;
      host_char(ASCII_LF, 1'b1);
      wait_empty();
      check_bit(rx_overrun, 1'b0);
      #1 port_enable = 1'b0;
      #1 check_bit(dsr, 1'b0);
      summarize();
   end
endmodule // serial_command_port_bench
`default_nettype wire
